/* pkg/rmii_port_defines.vh */
// constants for the uplink reduced media-independent interface port
// assumes a 20 MHz system clock and a sampled 50 MHz-class reference
`ifndef RMII_PORT_DEFINES_VH
`define RMII_PORT_DEFINES_VH
`define CLK_HZ            20000000
`define REF_HZ            50000000
`define SLOW_REPEAT       4'd10
`define SLOW_REPEAT_LAST  4'd9
`define REF_DIV_HALF      1'b1
`define REF_SEEN_EDGES    4'd4
`define REF_LOST_CYCLES   8'd64
`define CLK_MODE_BIT      7
`define STRAP_SETTLE      2'd2
`endif

/* logic/rmii_port.v */
// uplink reduced media-independent interface, dibit transmit and receive
// assumes reference clock arrives as a pin sampled by the system clock;
// the partner keeps its own rules on its side of the wires
//
// Behaviour
// - two line rates: ten or hundred megabit
// - one shared reference clock times transfers
// - clock mode drives reference out on pin
// - normal mode accepts reference on input pin
// - independent two-bit transmit and receive paths
// - normal mode reference clocks whole device when source strap set
// - strap selects device clock source
// - strap or config bit selects clock mode
// - normal mode waits for external reference
// - mac role: valid, error, dibit in
// - role follows wiring only, no strap
`timescale 1ns/1ps
`include "rmii_port_defines.vh"
module rmii_port (
  input  wire       clock,            // system clock, 20 MHz
  input  wire       rstn,             // asynchronous reset, active low
  input  wire       clock_mode_strap, // strap: 1 clock mode, 0 normal mode
  input  wire       clock_mode_reg,   // config bit 7 override value
  input  wire       clock_mode_sel,   // 1 uses config bit over strap
  input  wire       clock_source_strap, // 1 device clock from ref pin in normal mode
  input  wire       speed_100,        // 1 hundred megabit, 0 ten
  input  wire       ref_clock_in_pin, // reference clock input pin
  output reg        ref_clock_out_pin, // reference clock out, clock mode
  output reg        ref_clock_out_oe, // high while driving reference out
  output wire       device_clock_from_ref, // device clock source select
  output wire       port_ready,       // reference present, port running
  input  wire       uplink_tx_enable_pin, // partner's frame valid in
  input  wire [1:0] uplink_tx_dibit,  // partner's dibit in
  input  wire       uplink_tx_error_pin, // receive error in, mac role
  output reg        uplink_rx_valid_pin, // our frame valid out
  output reg  [1:0] uplink_rx_dibit,  // our dibit out
  input  wire [1:0] send_data,        // user dibit to send
  input  wire       send_valid,       // user dibit valid
  input  wire       send_last,        // user marks last dibit of frame
  output wire       send_ready,       // buffer accepts dibit
  output reg  [1:0] recv_data,        // received dibit
  output reg        recv_valid,       // received dibit pulse
  output reg        recv_error,       // received dibit carried error
  output reg        recv_end          // pulse at end of received frame
);
  // role is fixed by wiring: same ports serve mac and phy roles
  // mode and strap captures
  reg       clock_mode;               // latched mode after reset
  reg       source_ref;               // latched source after reset
  reg       straps_taken;             // straps caught once
  reg [1:0] strap_s1;                 // strap first stage, read by strap_s2
  reg [1:0] strap_s2;                 // strap second stage, source and mode
  reg [1:0] strap_wait;               // edges counted before the catch
  // reference synchroniser and edge finder
  reg       ref_s1;                   // first stage, read only by ref_s2
  reg       ref_s2;                   // second stage
  reg       ref_s3;                   // delayed copy for edge detect
  wire      ref_rise;                 // rising reference edge seen
  reg [3:0] edge_count;               // edges seen while hunting
  reg [7:0] quiet_count;              // cycles since last edge
  reg       ref_present;              // external reference detected
  reg       tick;                     // internal reference toggle
  wire      sample;                   // one-cycle sampling enable
  // input synchronisers for data pins
  reg [3:0] din_s1;                   // first stage, read only by din_s2
  reg [3:0] din_s2;                   // second stage
  // receive side repeat counter
  reg [3:0] rx_rep;                   // slow rate repeat count
  reg       rx_prev_valid;            // frame valid on previous symbol
  // two-entry transmit buffer
  reg [2:0] buf_mem [0:1];            // data and last flag
  reg       wr_ptr;                   // write pointer
  reg       rd_ptr;                   // read pointer
  reg [1:0] fill;                     // entries held
  wire      buf_valid;                // buffer has an entry
  wire      buf_take;                 // drain takes an entry
  reg [3:0] tx_rep;                   // slow rate repeat count
  reg       tx_tail;                  // a last dibit was sent

  assign ref_rise = ref_s2 & ~ref_s3;
  // clock mode runs on our own divider; normal waits on the pin
  assign sample = clock_mode ? tick : (ref_rise & ref_present);
  assign port_ready = clock_mode | ref_present;
  assign device_clock_from_ref = ~clock_mode & source_ref;
  assign buf_valid = (fill != 2'd0);
  assign send_ready = (fill != 2'd2);
  // drain only on a symbol boundary so slow symbols repeat whole;
  // a last dibit just sent holds the drain for one idle symbol
  assign buf_take = sample & port_ready & buf_valid & ~tx_tail &
                    (speed_100 | (tx_rep == `SLOW_REPEAT_LAST));

  // straps are pins: two stages first, then caught once after release
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_s1     <= 2'b00;
      strap_s2     <= 2'b00;
      strap_wait   <= 2'd0;
      clock_mode   <= 1'b0;
      source_ref   <= 1'b0;
      straps_taken <= 1'b0;
    end else begin
      strap_s1 <= {clock_source_strap, clock_mode_strap};
      strap_s2 <= strap_s1;
      if (!straps_taken) begin
        // wait until the second stage holds the strap, not its reset
        strap_wait <= strap_wait + 2'd1;
        if (strap_wait == `STRAP_SETTLE) begin
          straps_taken <= 1'b1;
          clock_mode   <= strap_s2[0];
          source_ref   <= strap_s2[1];
        end
      end else if (clock_mode_sel) begin
        clock_mode <= clock_mode_reg; // config bit wins once selected
      end
    end
  end

  // reference output: a divided enable, since a 20 MHz clock cannot make
  // a true 50 MHz wave; the pin toggles every cycle instead, one period per sample
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick              <= 1'b0;
      ref_clock_out_pin <= 1'b0;
      ref_clock_out_oe  <= 1'b0;
    end else begin
      tick              <= ~tick;
      ref_clock_out_oe  <= clock_mode;
      ref_clock_out_pin <= clock_mode & tick;
    end
  end

  // reference input synchroniser and presence detector
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_s1      <= 1'b0;
      ref_s2      <= 1'b0;
      ref_s3      <= 1'b0;
      edge_count  <= 4'h0;
      quiet_count <= 8'h00;
      ref_present <= 1'b0;
    end else begin
      ref_s1 <= ref_clock_in_pin;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      if (ref_rise) begin
        quiet_count <= 8'h00;
        if (edge_count != `REF_SEEN_EDGES)
          edge_count <= edge_count + 4'h1;
        else
          ref_present <= ~clock_mode;
      end else if (quiet_count == `REF_LOST_CYCLES) begin
        // reference gone: stop the port until it returns
        edge_count  <= 4'h0;
        ref_present <= 1'b0;
      end else begin
        quiet_count <= quiet_count + 8'h01;
      end
    end
  end

  // data pin synchronisers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      din_s1 <= 4'h0;
      din_s2 <= 4'h0;
    end else begin
      din_s1 <= {uplink_tx_error_pin, uplink_tx_enable_pin,
                 uplink_tx_dibit};
      din_s2 <= din_s1;
    end
  end

  // receive path, independent of transmit
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_rep        <= 4'h0;
      rx_prev_valid <= 1'b0;
      recv_data     <= 2'b00;
      recv_valid    <= 1'b0;
      recv_error    <= 1'b0;
      recv_end      <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      recv_end   <= 1'b0;
      if (sample & port_ready) begin
        rx_prev_valid <= din_s2[2];
        recv_end      <= rx_prev_valid & ~din_s2[2];
        if (!din_s2[2]) begin
          rx_rep <= 4'h0;
        end else if (speed_100 || rx_rep == 4'h0) begin
          recv_data  <= din_s2[1:0];
          recv_valid <= 1'b1;
          recv_error <= din_s2[3];
          rx_rep     <= speed_100 ? 4'h0 : `SLOW_REPEAT_LAST;
        end else begin
          rx_rep <= rx_rep - 4'h1; // slow symbol repeated
        end
      end
    end
  end

  // buffer words kept out of the reset process: storage needs no reset
  always @(posedge clock) begin
    if (send_valid && send_ready)
      buf_mem[wr_ptr] <= {send_last, send_data};
  end

  // two-entry buffer: a stalled drain fills it and drops send_ready
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'd0;
    end else begin
      if (send_valid && send_ready)
        wr_ptr <= ~wr_ptr;
      if (buf_take)
        rd_ptr <= ~rd_ptr;
      case ({send_valid & send_ready, buf_take})
        2'b10:   fill <= fill + 2'd1;
        2'b01:   fill <= fill - 2'd1;
        default: fill <= fill;
      endcase
    end
  end

  // transmit path: each dibit held ten samples at the slow rate
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_rep              <= 4'h0;
      tx_tail             <= 1'b0;
      uplink_rx_valid_pin <= 1'b0;
      uplink_rx_dibit     <= 2'b00;
    end else if (sample & port_ready) begin
      if (!speed_100 && tx_rep != `SLOW_REPEAT_LAST) begin
        tx_rep <= tx_rep + 4'h1;
      end else begin
        tx_rep <= 4'h0;
        if (buf_valid && !tx_tail) begin
          uplink_rx_valid_pin <= 1'b1;
          uplink_rx_dibit     <= buf_mem[rd_ptr][1:0];
          tx_tail             <= buf_mem[rd_ptr][2];
        end else begin
          // underrun or frame end drops valid; partner sees a gap, so
          // frames queued back to back never merge into one
          uplink_rx_valid_pin <= 1'b0;
          uplink_rx_dibit     <= 2'b00;
          tx_tail             <= 1'b0;
        end
      end
    end
  end
endmodule

/* dv/rmii_port_assertions.sv */
// timing checks for the uplink reduced mii port
// sees only rmii_port ports; bound in below the module
`timescale 1ns/1ps
module rmii_port_chk (
  input wire       clock,                 // system clock
  input wire       rstn,                  // reset, active low
  input wire       clock_source_strap,    // source strap
  input wire       speed_100,             // rate select
  input wire       ref_clock_out_pin,     // reference out
  input wire       ref_clock_out_oe,      // reference out enable
  input wire       device_clock_from_ref, // device clock source
  input wire       port_ready,            // reference present
  input wire       uplink_tx_enable_pin,  // frame valid in
  input wire [1:0] uplink_rx_dibit,       // dibit out
  input wire       recv_valid,            // receive pulse
  input wire       recv_end               // end of frame pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_OE_READY: assert property (ref_clock_out_oe |-> port_ready)
    else $error("reference driven while port not ready");
  AST_OUT_IDLE: assert property (
    !ref_clock_out_oe |-> !ref_clock_out_pin)
    else $error("reference pin high while not driven");
  AST_TOGGLE: assert property (
    ref_clock_out_oe [*3] |-> $changed(ref_clock_out_pin))
    else $error("reference out not toggling");
  AST_SOURCE: assert property (
    device_clock_from_ref |-> clock_source_strap)
    else $error("clock source not from strap");
  AST_QUIET: assert property (!port_ready |-> !recv_valid)
    else $error("receive while reference absent");
  AST_PULSE: assert property (recv_valid |=> !recv_valid)
    else $error("receive pulse longer than one cycle");
  AST_END: assert property (recv_end |=> !recv_end)
    else $error("end pulse longer than one cycle");
  AST_RX_LAT: assert property (
    port_ready && $rose(uplink_tx_enable_pin) |-> ##[2:24] recv_valid)
    else $error("incoming frame not received in time");
  AST_SLOW: assert property (
    !speed_100 && $changed(uplink_rx_dibit) |=> $stable(uplink_rx_dibit) [*8])
    else $error("slow symbol not held");
endmodule
bind rmii_port rmii_port_chk i_chk (.clock, .rstn, .clock_source_strap,
  .speed_100, .ref_clock_out_pin, .ref_clock_out_oe, .device_clock_from_ref,
  .port_ready, .uplink_tx_enable_pin, .uplink_rx_dibit, .recv_valid,
  .recv_end);

/* dv/rmii_far_end.sv */
// far end of the uplink port: free running reference, dibit lines
// assumes the device samples on reference rising edges
`timescale 1ns/1ps
module rmii_far_end (
  input  wire       run,      // oscillator enabled
  output reg        ref_clk,  // reference, 400 ns in the bench
  output reg        tx_en,    // frame valid toward device
  output reg  [1:0] tx_dibit, // dibit toward device
  output reg        tx_err,   // error toward device
  input  wire       rx_valid, // frame valid from device
  input  wire [1:0] rx_dibit  // dibit from device
);
  logic [1:0] got[$];       // dibits seen from the device
  int         frames = 0;   // falls of the device's frame valid
  reg         was_valid = 0; // frame valid at the previous rising edge
  initial begin
    ref_clk = 0;
    tx_en = 0;
    tx_err = 0;
    tx_dibit = 2'h0;
  end
  // oscillator runs free, not only in frames
  always #200 ref_clk = run & ~ref_clk;
  // take device symbols on rising edges and count frame ends
  always @(posedge ref_clk) begin
    if (rx_valid) got.push_back(rx_dibit);
    if (was_valid && !rx_valid) frames++;
    was_valid = rx_valid;
  end
  // change lines on falling edges so they are settled when sampled;
  // each dibit is held rep reference periods
  task send(input logic [7:0] d, input logic [3:0] e, input int rep);
    for (int i = 0; i < 4 * rep; i++) begin
      @(negedge ref_clk);
      tx_en = 1;
      tx_dibit = d[2*(i/rep) +: 2];
      tx_err = e[i/rep];
    end
    @(negedge ref_clk);
    tx_en = 0;
    tx_err = 0;
    tx_dibit = ~tx_dibit; // released line shows no stale value
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the uplink reduced mii port
// assumes rmii_port with far end model and bound checker
`timescale 1ns/1ps
module testbench;
  reg        clock = 0, rstn = 0, speed_100 = 1, run = 1, send_valid = 0;
  reg        clock_mode_reg = 0, clock_mode_sel = 0, refused = 0;
  reg        clock_mode_strap = 0, clock_source_strap = 1, send_last = 0;
  reg  [1:0] send_data = 2'h0;
  wire       ref_clock_in_pin, ref_clock_out_pin, ref_clock_out_oe;
  wire       device_clock_from_ref, port_ready, send_ready;
  wire       uplink_tx_enable_pin, uplink_tx_error_pin, uplink_rx_valid_pin;
  wire       recv_valid, recv_error, recv_end;
  wire [1:0] uplink_tx_dibit, uplink_rx_dibit, recv_data;
  logic [2:0] rx_q[$]; // error and dibit per received symbol
  int fails, n_tests, ends, k, frames0;
  rmii_port i_dut (.clock, .rstn, .clock_mode_strap, .clock_mode_reg,
    .clock_mode_sel, .clock_source_strap, .speed_100,
    .ref_clock_in_pin, .ref_clock_out_pin, .ref_clock_out_oe,
    .device_clock_from_ref, .port_ready, .uplink_tx_enable_pin,
    .uplink_tx_dibit, .uplink_tx_error_pin, .uplink_rx_valid_pin,
    .uplink_rx_dibit, .send_data, .send_valid, .send_last, .send_ready,
    .recv_data, .recv_valid, .recv_error, .recv_end);
  rmii_far_end i_far (.run, .ref_clk(ref_clock_in_pin),
    .tx_en(uplink_tx_enable_pin), .tx_dibit(uplink_tx_dibit),
    .tx_err(uplink_tx_error_pin), .rx_valid(uplink_rx_valid_pin),
    .rx_dibit(uplink_rx_dibit));
  always #25 clock = ~clock;
  // collect received symbols and frame ends
  always @(posedge clock) begin
    if (recv_valid === 1) rx_q.push_back({recv_error, recv_data});
    if (recv_end === 1) ends++;
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wait_cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  // offer one dibit and hold it until taken
  task push(input logic [1:0] d, input logic l);
    send_data <= d;
    send_last <= l;
    send_valid <= 1;
    @(posedge clock);
    while (send_ready !== 1) begin
      refused = 1;
      @(posedge clock);
    end
  endtask
  task t_reset;
    chk("reset outs", 0,
        {port_ready, ref_clock_out_oe, uplink_rx_valid_pin});
    for (k = 0; k < 100 && port_ready !== 1; k++) @(posedge clock);
    chk("ready", 1, port_ready);
    chk("src", 1, device_clock_from_ref);
    chk("oe", 0, ref_clock_out_oe);
    $display("test reset done");
  endtask
  // one incoming frame of four dibits, each held rep reference periods
  task t_rx(input logic s, input int rep);
    rx_q.delete();
    ends = 0;
    speed_100 <= s;
    i_far.send(8'he4, 4'h4, rep);
    wait_cycles(40);
    chk("rx count", 4, rx_q.size());
    for (k = 0; k < 4; k++) chk("rx", {k == 2, 2'(k)}, rx_q[k]);
    chk("ends", 1, ends);
    $display("test receive done");
  endtask
  // dibits 3, 1, 2 out; split ends a frame after the second dibit
  task t_tx(input logic s, input int rep, input logic split);
    i_far.got.delete();
    frames0 = i_far.frames;
    speed_100 <= s;
    push(2'h3, 0);
    push(2'h1, split);
    push(2'h2, 1);
    send_valid <= 0;
    wait_cycles(rep * 40 + 40);
    chk("tx count", 3 * rep, i_far.got.size());
    for (k = 0; k < 3 * rep; k++)
      chk("tx", 2'(8'h27 >> (2 * (k / rep))), i_far.got[k]);
    chk("frames", 1 + split, i_far.frames - frames0);
    $display("test send done");
  endtask
  task t_loss;
    run <= 0;
    wait_cycles(100);
    chk("lost", 0, port_ready);
    clock_mode_sel <= 1;
    clock_mode_reg <= 1;
    wait_cycles(4);
    chk("clk mode", 3, {port_ready, ref_clock_out_oe});
    chk("src clk", 0, device_clock_from_ref);
    $display("test clock mode done");
  endtask
  // second reset with the mode strap set: clock mode without the config bit
  task t_strap;
    clock_mode_sel <= 0;
    clock_mode_strap <= 1;
    rstn <= 0;
    wait_cycles(2);
    rstn <= 1;
    chk("strap reset", 0, {port_ready, ref_clock_out_oe});
    wait_cycles(6);
    chk("strap mode", 3, {port_ready, ref_clock_out_oe});
    chk("strap src", 0, device_clock_from_ref);
    k = ref_clock_out_pin;
    wait_cycles(1);
    chk("ref out", !k, ref_clock_out_pin);
    $display("test strap done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    wait_cycles(2);
    rstn <= 1;
    t_reset;
    t_rx(1, 1);
    t_rx(0, 10);
    t_tx(1, 1, 1);
    t_tx(0, 10, 0);
    chk("refused", 1, refused);
    speed_100 <= 1;
    t_loss;
    t_strap;
    end_of_test;
  end
  initial begin
    #250000;
    fails++;
    end_of_test;
  end
endmodule
